// ---- common/dupd_params.svh ----
// Constants for the dual serial port decode and interrupt glue
`ifndef DUPD_PARAMS_SVH
`define DUPD_PARAMS_SVH

// ****************************************
// Fixed register address
// ****************************************
`define DUPD_DMA_REG_ADDR      16'h02F7

// ****************************************
// Reset values
// ****************************************
`define DUPD_OPTION_RESET      8'h00
`define DUPD_DMA_EN_RESET      8'h00
`define DUPD_ADDR_RESET        16'h0000
`define DUPD_BYTE_RESET        8'h00
`define DUPD_CTL_RESET         8'hFF
`define DUPD_REG_ADDR_RESET    3'h0

// ****************************************
// Option byte a field positions
// ****************************************
`define DUPD_CARD_ENABLE_BIT   0
`define DUPD_ONE_LOW_NAND_BIT  6
`define DUPD_ONE_A8_BIT        5
`define DUPD_ONE_A3_BIT        4
`define DUPD_TWO_LOW_NAND_BIT  3
`define DUPD_TWO_A8_BIT        2
`define DUPD_TWO_A3_BIT        1

// ****************************************
// Option byte b field positions
// ****************************************
`define DUPD_ONE_UPPER_MSB     5
`define DUPD_ONE_UPPER_LSB     3
`define DUPD_TWO_UPPER_MSB     2
`define DUPD_TWO_UPPER_LSB     0

// ****************************************
// Synchronised control pin positions
// ****************************************
`define DUPD_CTL_CMD_N         0
`define DUPD_CTL_MEM_IO        1
`define DUPD_CTL_IOR_N         2
`define DUPD_CTL_IOW_N         3
`define DUPD_CTL_BUF_DIR       4
`define DUPD_CTL_BUF_GATE_N    5
`define DUPD_CTL_IRQ_ONE       6
`define DUPD_CTL_IRQ_TWO       7

// ****************************************
// Interrupt status bit positions
// ****************************************
`define DUPD_ISR_IRQ_ONE       0
`define DUPD_ISR_IRQ_TWO       1
`define DUPD_ISR_TC            2

`endif

// ---- common/dupd_pkg.sv ----
// Types for the dual serial port decode and interrupt glue
package dupd_pkg;

    // ****************************************
    // Bus cycle states
    // ****************************************
    typedef enum logic [0:0] {
        DUPD_IDLE   = 1'b0,
        DUPD_ACTIVE = 1'b1
    } dupd_cycle_type;

    // ****************************************
    // Whole state of the top module
    // ****************************************
    typedef struct packed {
        logic [15:0]    addrMeta;
        logic [15:0]    addrSync;
        logic [7:0]     ctlMeta;
        logic [7:0]     ctlSync;
        logic [7:0]     dataMeta;
        logic [7:0]     dataSync;
        logic [7:0]     uartMeta;
        logic [7:0]     uartSync;
        dupd_cycle_type cycle;
        logic [2:0]     regAddr;
        logic           selOne_n;
        logic           selTwo_n;
        logic           liveOne_n;
        logic           liveTwo_n;
        logic           isrRead;
        logic [7:0]     optionByteA;
        logic [7:0]     optionByteB;
        logic [7:0]     dmaEnable;
        logic           irqLowOe;
        logic           irqHighOe;
        logic           cardSelect;
        logic [7:0]     hostOut;
        logic           hostOe;
        logic [7:0]     intOut;
        logic           intOe;
    } dupd_state_type;

endpackage : dupd_pkg

// ---- logic/dupd_chan_match.sv ----
// One serial channel address comparator
`timescale 1ns/1ps
`include "dupd_params.svh"

module dupd_chan_match (
    input  wire logic [15:3] addr,
    input  wire logic        isIo,
    input  wire logic        cardEnable,
    input  wire logic        lowNandCfg,
    input  wire logic        a8Cfg,
    input  wire logic        a3Cfg,
    input  wire logic [2:0]  upperCfg,
    output logic             select_n
);

    logic upperMatch_n;
    logic norHigh;
    logic nandMid;
    logic nandLow;

    // ****************************************
    // Compressed address bits
    // ****************************************
    always_comb begin
        norHigh      = ~(addr[15] | addr[11] | addr[10]);
        nandMid      = ~(addr[9] & addr[5]);
        nandLow      = ~(addr[7] & addr[6] & addr[4]);
        upperMatch_n = (addr[14:12] != upperCfg);
    end

    // ****************************************
    // Comparator, gated to I/O cycles
    // ****************************************
    always_comb begin
        select_n = ~(norHigh == 1'b1
                   && nandMid == 1'b0
                   && nandLow == lowNandCfg
                   && addr[8] == a8Cfg
                   && addr[3] == a3Cfg
                   && upperMatch_n == 1'b0
                   && cardEnable == 1'b1
                   && isIo);
    end

endmodule : dupd_chan_match

// ---- logic/dupd_irq_route.sv ----
// Routes serial and terminal count interrupts onto two request lines
`timescale 1ns/1ps

module dupd_irq_route (
    input  wire logic uartIrqOne,
    input  wire logic uartIrqTwo,
    input  wire logic tcIrq,
    input  wire logic oneAtFirstBase,
    input  wire logic twoAtFirstBase,
    output logic      irqLowAssert,
    output logic      irqHighAssert
);

    // ****************************************
    // Line selection from stored address bit 8
    // ****************************************
    always_comb begin
        irqLowAssert  = tcIrq
                      | (uartIrqOne & ~oneAtFirstBase)
                      | (uartIrqTwo & ~twoAtFirstBase);
        irqHighAssert = (uartIrqOne & oneAtFirstBase)
                      | (uartIrqTwo & twoAtFirstBase);
    end

endmodule : dupd_irq_route

// ---- logic/dupd_port_decode.sv ----
// Dual serial port address decode, UART select latch and interrupt routing
// Functional notes
// - Each channel sits at any of eight standard serial port bases.
// - Upper thirteen address bits decoded; low three go to the UART.
// - NOR of address bits 15, 11, 10 must be one.
// - NAND of address bits 9 and 5 must be zero.
// - NAND of bits 7, 6, 4 matches option a bit 6 or 3.
// - Address bit 8 matches option a bit 5 or 2.
// - Address bit 3 matches option a bit 4 or 1.
// - Address bits 14-12 match option b bits 5-3 or 2-0.
// - Serial decode off until card enable bit is set; resets to zero.
// - Matches only during I/O cycles, never memory cycles.
// - Each comparator drives its own active-low channel select.
// - Fixed address 2F7 holds write-only DMA enable, read-only interrupt status.
// - Register address and selects captured on command strobe, held for cycle.
// - UART chip select is AND of both latched active-low selects.
// - Latched channel-two select drives the UART channel pick.
// - UART accesses finish in the default cycle without wait states.
// - Request lines active-low, level, open-drain for sharing.
// - Low line for terminal count or non-first-base channel; high for first base.
// - Line choice per channel uses stored address bit 8 option bits.
// - Data isolation buffer steered by direction and active-low gate.
`timescale 1ns/1ps
`include "dupd_params.svh"

module dupd_port_decode (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] hostAddr,
    input  wire logic        memIo,
    input  wire logic        cmd_n,
    input  wire logic        ioRead_n,
    input  wire logic        ioWrite_n,
    input  wire logic        buffer_direction,
    input  wire logic        buffer_gate_n,
    input  wire logic        uart_irq_one,
    input  wire logic        uart_irq_two,
    input  wire logic        tcIrq,
    input  wire logic        optionWriteA,
    input  wire logic        optionWriteB,
    input  wire logic [7:0]  optionData,
    input  wire logic [7:0]  hostDataIn,
    output logic [7:0]       hostDataOut,
    output logic             hostDataOe,
    input  wire logic [7:0]  intDataIn,
    output logic [7:0]       intDataOut,
    output logic             intDataOe,
    output logic             channel_one_select_n,
    output logic             channel_two_select_n,
    output logic             cardSelect,
    output logic [2:0]       uartRegAddr,
    output logic             uartChipSelect_n,
    output logic             uart_channel_pick,
    output logic [7:0]       dma_request_enable,
    output logic [7:0]       option_byte_a,
    output logic [7:0]       option_byte_b,
    output logic             card_enable,
    output logic             irqLowOut,
    output logic             irqLowOe,
    output logic             irqHighOut,
    output logic             irqHighOe
);

    dupd_pkg::dupd_state_type stateQ;
    dupd_pkg::dupd_state_type stateD;

    logic       liveOne_n;
    logic       liveTwo_n;
    logic       dmaHit;
    logic       cmdActive;
    logic       isIo;
    logic       irqLowAssert;
    logic       irqHighAssert;
    logic [7:0] interrupt_status;

    // ****************************************
    // Decoding of the fixed register address
    // ****************************************
    function automatic logic is_dma_reg(input logic [15:0] addr);
        is_dma_reg = (addr == `DUPD_DMA_REG_ADDR);
    endfunction : is_dma_reg

    // ****************************************
    // Decoded views of synchronised pins
    // ****************************************
    always_comb begin
        cmdActive = ~stateQ.ctlSync[`DUPD_CTL_CMD_N];
        isIo      = ~stateQ.ctlSync[`DUPD_CTL_MEM_IO];
        dmaHit    = is_dma_reg(stateQ.addrSync) & isIo;
    end

    // ****************************************
    // Channel comparators
    // ****************************************
    dupd_chan_match u_match_one (
        .addr       (stateQ.addrSync[15:3]),
        .isIo       (isIo),
        .cardEnable (stateQ.optionByteA[`DUPD_CARD_ENABLE_BIT]),
        .lowNandCfg (stateQ.optionByteA[`DUPD_ONE_LOW_NAND_BIT]),
        .a8Cfg      (stateQ.optionByteA[`DUPD_ONE_A8_BIT]),
        .a3Cfg      (stateQ.optionByteA[`DUPD_ONE_A3_BIT]),
        .upperCfg   (stateQ.optionByteB[`DUPD_ONE_UPPER_MSB:`DUPD_ONE_UPPER_LSB]),
        .select_n   (liveOne_n)
    );

    dupd_chan_match u_match_two (
        .addr       (stateQ.addrSync[15:3]),
        .isIo       (isIo),
        .cardEnable (stateQ.optionByteA[`DUPD_CARD_ENABLE_BIT]),
        .lowNandCfg (stateQ.optionByteA[`DUPD_TWO_LOW_NAND_BIT]),
        .a8Cfg      (stateQ.optionByteA[`DUPD_TWO_A8_BIT]),
        .a3Cfg      (stateQ.optionByteA[`DUPD_TWO_A3_BIT]),
        .upperCfg   (stateQ.optionByteB[`DUPD_TWO_UPPER_MSB:`DUPD_TWO_UPPER_LSB]),
        .select_n   (liveTwo_n)
    );

    // ****************************************
    // Interrupt routing
    // ****************************************
    dupd_irq_route u_irq_route (
        .uartIrqOne     (stateQ.ctlSync[`DUPD_CTL_IRQ_ONE]),
        .uartIrqTwo     (stateQ.ctlSync[`DUPD_CTL_IRQ_TWO]),
        .tcIrq          (tcIrq),
        .oneAtFirstBase (stateQ.optionByteA[`DUPD_ONE_A8_BIT]),
        .twoAtFirstBase (stateQ.optionByteA[`DUPD_TWO_A8_BIT]),
        .irqLowAssert   (irqLowAssert),
        .irqHighAssert  (irqHighAssert)
    );

    // ****************************************
    // Interrupt status image
    // ****************************************
    always_comb begin
        interrupt_status                    = 8'h00;
        interrupt_status[`DUPD_ISR_IRQ_ONE] = stateQ.ctlSync[`DUPD_CTL_IRQ_ONE];
        interrupt_status[`DUPD_ISR_IRQ_TWO] = stateQ.ctlSync[`DUPD_CTL_IRQ_TWO];
        interrupt_status[`DUPD_ISR_TC]      = tcIrq;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        stateD = stateQ;

        // ****************************************
        // Two-stage synchronisers on all pins except tcIrq and the option inputs
        // ****************************************
        stateD.addrMeta = hostAddr;
        stateD.addrSync = stateQ.addrMeta;
        stateD.ctlMeta  = {uart_irq_two,
                           uart_irq_one,
                           buffer_gate_n,
                           buffer_direction,
                           ioWrite_n,
                           ioRead_n,
                           memIo,
                           cmd_n};
        stateD.ctlSync  = stateQ.ctlMeta;
        stateD.dataMeta = hostDataIn;
        stateD.dataSync = stateQ.dataMeta;
        stateD.uartMeta = intDataIn;
        stateD.uartSync = stateQ.uartMeta;

        // ****************************************
        // Unlatched decodes
        // ****************************************
        stateD.liveOne_n  = liveOne_n;
        stateD.liveTwo_n  = liveTwo_n;
        stateD.cardSelect = ~liveOne_n | ~liveTwo_n | dmaHit;

        // ****************************************
        // Option bytes written during setup
        // ****************************************
        if (optionWriteA) begin
            stateD.optionByteA = optionData;
        end
        if (optionWriteB) begin
            stateD.optionByteB = optionData;
        end

        // ****************************************
        // Bus cycle latch
        // ****************************************
        case (stateQ.cycle)
            dupd_pkg::DUPD_IDLE: begin
                stateD.selOne_n = 1'b1;
                stateD.selTwo_n = 1'b1;
                stateD.isrRead  = 1'b0;
                if (cmdActive) begin
                    stateD.cycle    = dupd_pkg::DUPD_ACTIVE;
                    stateD.regAddr  = stateQ.addrSync[2:0];
                    stateD.selOne_n = liveOne_n;
                    stateD.selTwo_n = liveTwo_n;
                    stateD.isrRead  = dmaHit & ~stateQ.ctlSync[`DUPD_CTL_IOR_N];
                    if (dmaHit && !stateQ.ctlSync[`DUPD_CTL_IOW_N]) begin
                        stateD.dmaEnable = stateQ.dataSync;
                    end
                end
            end
            dupd_pkg::DUPD_ACTIVE: begin
                // Held with no wait state until the strobe ends
                if (!cmdActive) begin
                    stateD.cycle    = dupd_pkg::DUPD_IDLE;
                    stateD.selOne_n = 1'b1;
                    stateD.selTwo_n = 1'b1;
                    stateD.isrRead  = 1'b0;
                end
            end
            default: begin
                stateD.cycle = dupd_pkg::DUPD_IDLE;
            end
        endcase

        // ****************************************
        // Data isolation buffer
        // ****************************************
        stateD.hostOe  = ~stateQ.ctlSync[`DUPD_CTL_BUF_GATE_N]
                       & stateQ.ctlSync[`DUPD_CTL_BUF_DIR];
        stateD.intOe   = ~stateQ.ctlSync[`DUPD_CTL_BUF_GATE_N]
                       & ~stateQ.ctlSync[`DUPD_CTL_BUF_DIR];
        stateD.hostOut = stateQ.isrRead ? interrupt_status : stateQ.uartSync;
        stateD.intOut  = stateQ.dataSync;

        // ****************************************
        // Open-drain request lines
        // ****************************************
        stateD.irqLowOe  = irqLowAssert;
        stateD.irqHighOe = irqHighAssert;
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ.addrMeta    <= `DUPD_ADDR_RESET;
            stateQ.addrSync    <= `DUPD_ADDR_RESET;
            stateQ.ctlMeta     <= `DUPD_CTL_RESET;
            stateQ.ctlSync     <= `DUPD_CTL_RESET;
            stateQ.dataMeta    <= `DUPD_BYTE_RESET;
            stateQ.dataSync    <= `DUPD_BYTE_RESET;
            stateQ.uartMeta    <= `DUPD_BYTE_RESET;
            stateQ.uartSync    <= `DUPD_BYTE_RESET;
            stateQ.cycle       <= dupd_pkg::DUPD_IDLE;
            stateQ.regAddr     <= `DUPD_REG_ADDR_RESET;
            stateQ.selOne_n    <= 1'b1;
            stateQ.selTwo_n    <= 1'b1;
            stateQ.liveOne_n   <= 1'b1;
            stateQ.liveTwo_n   <= 1'b1;
            stateQ.isrRead     <= 1'b0;
            stateQ.optionByteA <= `DUPD_OPTION_RESET;
            stateQ.optionByteB <= `DUPD_OPTION_RESET;
            stateQ.dmaEnable   <= `DUPD_DMA_EN_RESET;
            stateQ.irqLowOe    <= 1'b0;
            stateQ.irqHighOe   <= 1'b0;
            stateQ.cardSelect  <= 1'b0;
            stateQ.hostOut     <= `DUPD_BYTE_RESET;
            stateQ.hostOe      <= 1'b0;
            stateQ.intOut      <= `DUPD_BYTE_RESET;
            stateQ.intOe       <= 1'b0;
        end else begin
            stateQ <= stateD;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_comb begin
        channel_one_select_n = stateQ.liveOne_n;
        channel_two_select_n = stateQ.liveTwo_n;
        cardSelect           = stateQ.cardSelect;
        uartRegAddr          = stateQ.regAddr;
        uartChipSelect_n     = stateQ.selOne_n & stateQ.selTwo_n;
        uart_channel_pick    = stateQ.selTwo_n;
    end

    // ****************************************
    // Configuration outputs
    // ****************************************
    always_comb begin
        dma_request_enable   = stateQ.dmaEnable;
        option_byte_a        = stateQ.optionByteA;
        option_byte_b        = stateQ.optionByteB;
        card_enable          = stateQ.optionByteA[`DUPD_CARD_ENABLE_BIT];
    end

    // ****************************************
    // Data buffer and request line outputs
    // ****************************************
    always_comb begin
        hostDataOut          = stateQ.hostOut;
        hostDataOe           = stateQ.hostOe;
        intDataOut           = stateQ.intOut;
        intDataOe            = stateQ.intOe;
        irqLowOut            = 1'b0;
        irqLowOe             = stateQ.irqLowOe;
        irqHighOut           = 1'b0;
        irqHighOe            = stateQ.irqHighOe;
    end

endmodule : dupd_port_decode

// ---- verification/dupd_port_decode_chk.sv ----
// Assertion checker for the dual serial port decoder
`timescale 1ns/1ps

module dupd_port_decode_chk (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       memIo,
    input wire logic       cmd_n,
    input wire logic       uart_irq_one,
    input wire logic       uart_irq_two,
    input wire logic       tcIrq,
    input wire logic       optionWriteA,
    input wire logic [7:0] optionData,
    input wire logic       channel_one_select_n,
    input wire logic       channel_two_select_n,
    input wire logic [2:0] uartRegAddr,
    input wire logic       uartChipSelect_n,
    input wire logic       uart_channel_pick,
    input wire logic [7:0] option_byte_a,
    input wire logic       card_enable,
    input wire logic       irqLowOut,
    input wire logic       irqLowOe,
    input wire logic       irqHighOut,
    input wire logic       irqHighOe
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_CARD_OFF: assert property (!card_enable [*3] |-> channel_one_select_n && channel_two_select_n)
        else $error("channel select while card disabled");
    AST_MEM_CYCLE: assert property (memIo [*5] |-> channel_one_select_n && channel_two_select_n)
        else $error("channel select during memory cycle");
    AST_PICK: assert property ($fell(uartChipSelect_n) |-> uart_channel_pick == channel_two_select_n
        && !(channel_one_select_n && channel_two_select_n))
        else $error("latched pick differs from channel select");
    AST_IDLE_CS: assert property (cmd_n [*5] |-> uartChipSelect_n)
        else $error("chip select outside bus cycle");
    AST_HOLD: assert property (!cmd_n [*6] |-> $stable(uartRegAddr) && $stable(uart_channel_pick)
        && $stable(uartChipSelect_n))
        else $error("latched select moved in cycle");
    AST_TC: assert property (tcIrq |=> irqLowOe)
        else $error("terminal count not on low line");
    AST_NO_HIGH: assert property ((!uart_irq_one && !uart_irq_two) [*4] |-> !irqHighOe)
        else $error("high line without channel request");
    AST_HIGH_ONE: assert property ((uart_irq_one && option_byte_a[5]) [*4] |-> irqHighOe)
        else $error("first base channel not on high line");
    AST_OPEN_DRAIN: assert property (!irqLowOut && !irqHighOut)
        else $error("request line driven high");
    AST_OPT_WR: assert property (optionWriteA |=> option_byte_a == $past(optionData)
        && card_enable == option_byte_a[0])
        else $error("option byte a write lost");

    cover property (!channel_one_select_n);
    cover property (!uartChipSelect_n && uart_channel_pick);
    cover property (irqHighOe);
endmodule : dupd_port_decode_chk

bind dupd_port_decode dupd_port_decode_chk u_chk (.*);

// ---- verification/dupd_uart_model.sv ----
// Behavioural serial device answering register reads on the internal bus
`timescale 1ns/1ps

module dupd_uart_model (
    input  wire logic       chipSelect_n,
    input  wire logic       channelPick,
    input  wire logic [2:0] regAddr,
    output logic      [7:0] rdData
);
    logic [7:0] lastVal = 8'h00;

    always @* begin
        if (!chipSelect_n) begin
            lastVal = {3'b101, channelPick, 1'b0, regAddr};
        end
    end

    // Released bus shows the inverse of the last value
    assign rdData = chipSelect_n ? ~lastVal : {3'b101, channelPick, 1'b0, regAddr};
endmodule : dupd_uart_model

// ---- verification/dupd_testbench.sv ----
// Self-checking bench for the dual serial port decoder
`timescale 1ns/1ps

module testbench;
    logic        clk = 1'b0, rst_n = 1'b0, memIo = 1'b1, cmd_n = 1'b1, ioRead_n = 1'b1, ioWrite_n = 1'b1;
    logic        buffer_direction = 1'b0, buffer_gate_n = 1'b1, uart_irq_one = 1'b0, uart_irq_two = 1'b0;
    logic        tcIrq = 1'b0, optionWriteA = 1'b0, optionWriteB = 1'b0;
    logic [15:0] hostAddr = 16'h0000, b1, b2;
    logic [7:0]  optionData = 8'h00, hostDataIn = 8'h00, intDataIn, hostDataOut, intDataOut, d;
    logic [7:0]  dma_request_enable, option_byte_a, option_byte_b, mA = 8'h00, mB = 8'h00;
    logic        hostDataOe, intDataOe, channel_one_select_n, channel_two_select_n, cardSelect, ch, mMem;
    logic        uartChipSelect_n, uart_channel_pick, card_enable, irqLowOut, irqLowOe, irqHighOut, irqHighOe;
    logic [2:0]  uartRegAddr, rg;
    int          err_count = 0, checked = 0;
    logic [15:0] bases [8] = '{16'h03F8, 16'h02F8, 16'h3220, 16'h3228,
                               16'h4220, 16'h4228, 16'h5220, 16'h5228};

    always #50 clk = ~clk;

    dupd_port_decode u_dut (.*);
    dupd_uart_model u_uart (.chipSelect_n(uartChipSelect_n), .channelPick(uart_channel_pick),
                            .regAddr(uartRegAddr), .rdData(intDataIn));

    // ****************************************
    // Helpers and model
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkByte

    task automatic chkBit(input logic got, input logic exp);
        chkByte({7'h00, got}, {7'h00, exp});
    endtask : chkBit

    task automatic setOpt(input logic [7:0] a, input logic [7:0] b);
        optionWriteA = 1'b1;
        optionData = a;
        tick(1);
        optionWriteA = 1'b0;
        optionWriteB = 1'b1;
        optionData = b;
        tick(1);
        optionWriteB = 1'b0;
        mA = a;
        mB = b;
    endtask : setOpt

    function automatic logic [2:0] lowBits(input logic [15:0] b);
        return {~(b[7] & b[6] & b[4]), b[8], b[3]};
    endfunction : lowBits

    function automatic logic msel(input logic [15:0] a, input logic c);
        logic [5:0] f;
        f = c ? {mA[3:1], mB[2:0]} : {mA[6:4], mB[5:3]};
        return mA[0] && !mMem && !(a[15] | a[11] | a[10]) && (a[9] & a[5]) && (~(a[7] & a[6] & a[4]) == f[5])
            && (a[8] == f[4]) && (a[3] == f[3]) && (a[14:12] == f[2:0]);
    endfunction : msel

    task automatic busCycle(input logic [15:0] a, input logic rd, input logic [7:0] dat);
        hostAddr = a;
        memIo = 1'b0;
        ioRead_n = !rd;
        ioWrite_n = rd;
        buffer_direction = rd;
        buffer_gate_n = 1'b0;
        hostDataIn = dat;
        tick(3);
        cmd_n = 1'b0;
        tick(8);
    endtask : busCycle

    task automatic busEnd;
        cmd_n = 1'b1;
        ioRead_n = 1'b1;
        ioWrite_n = 1'b1;
        buffer_gate_n = 1'b1;
        tick(5);
    endtask : busEnd

    task automatic report_and_stop;
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #500_000;
        err_count++;
        report_and_stop;
    end

    initial begin
        void'($urandom(81));
        tick(3);
        chkByte(option_byte_a, 8'h00);
        chkByte(dma_request_enable, 8'h00);
        chkBit(uartChipSelect_n, 1'b1);
        rst_n = 1'b1;
        tick(2);
        for (int i = 0; i < 9; i++) begin
            b1 = bases[i % 8];
            b2 = bases[(i + 1 + $urandom % 7) % 8];
            setOpt({1'b0, lowBits(b1), lowBits(b2), i < 8}, {2'b00, b1[14:12], b2[14:12]});
            chkByte(option_byte_a, mA);
            chkByte(option_byte_b, mB);
            for (int k = 0; k < 6; k++) begin
                hostAddr = (k[0] ? b2 : b1) | 16'($urandom % 8);
                if (k > 1) hostAddr = hostAddr ^ (16'h0008 << ($urandom % 13));
                if (k == 4) hostAddr = 16'($urandom);
                if (k == 5) hostAddr = 16'h02F7;
                memIo = ($urandom % 4) == 0;
                mMem = memIo;
                tick(4);
                chkBit(channel_one_select_n, !msel(hostAddr, 1'b0));
                chkBit(channel_two_select_n, !msel(hostAddr, 1'b1));
                if (i < 8) chkBit(cardSelect, !memIo && (msel(hostAddr, 1'b0) || msel(hostAddr, 1'b1)
                    || hostAddr == 16'h02F7));
            end
        end
        $display("decode sweep done");
        setOpt({1'b0, lowBits(bases[0]), lowBits(bases[4]), 1'b1}, {2'b00, bases[0][14:12], bases[4][14:12]});
        mMem = 1'b0;
        for (int r = 0; r < 6; r++) begin
            ch = r[0];
            rg = 3'($urandom);
            busCycle((ch ? bases[4] : bases[0]) | 16'(rg), 1'b1, 8'h00);
            for (int h = 0; h < 2; h++) begin
                chkByte(8'(uartRegAddr), 8'(rg));
                chkBit(uartChipSelect_n, 1'b0);
                chkBit(uart_channel_pick, !ch);
                chkByte(hostDataOut, {3'b101, !ch, 1'b0, rg});
                chkBit(hostDataOe, 1'b1);
                hostAddr = 16'h0100;
                tick(4);
            end
            busEnd;
        end
        busCycle(16'h0100, 1'b1, 8'h00);
        chkBit(uartChipSelect_n, 1'b1);
        busEnd;
        $display("uart cycles done");
        d = 8'($urandom);
        busCycle(16'h02F7, 1'b0, d);
        chkBit(hostDataOe, 1'b0);
        chkBit(intDataOe, 1'b1);
        chkByte(intDataOut, d);
        busEnd;
        chkByte(dma_request_enable, d);
        uart_irq_one = 1'b1;
        tcIrq = 1'b1;
        busCycle(16'h02F7, 1'b1, 8'h00);
        chkByte(hostDataOut, 8'h05);
        chkBit(uartChipSelect_n, 1'b1);
        busEnd;
        chkByte(dma_request_enable, d);
        $display("fixed register done");
        for (int v = 0; v < 32; v++) begin
            setOpt({2'b00, v[4], 2'b00, v[3], 2'b01}, 8'h00);
            {tcIrq, uart_irq_two, uart_irq_one} = v[2:0];
            tick(5);
            chkBit(irqLowOe, v[2] | (v[0] & !v[4]) | (v[1] & !v[3]));
            chkBit(irqHighOe, (v[0] & v[4]) | (v[1] & v[3]));
            chkBit(irqLowOut | irqHighOut, 1'b0);
        end
        $display("interrupt routing done");
        report_and_stop;
    end
endmodule : testbench
